// ---- design/acp_pkg.sv ----
// Constants, status layout and opcode table of the arithmetic coprocessor host port.
// Assumes a single 125 MHz system clock; imported whole by the top module.
package acp_pkg;

  // ************************************************************
  // Stack geometry
  // ************************************************************
  localparam int unsigned STK_BYTES = 16;    // Eight short or four long quantities
  localparam int unsigned PTR_W     = 4;
  localparam int unsigned FIFO_W    = 8;
  localparam int unsigned FIFO_D    = 32;

  // ************************************************************
  // Status byte layout and error codes
  // ************************************************************
  localparam int unsigned ST_BUSY   = 7;
  localparam int unsigned ST_SIGN   = 6;
  localparam int unsigned ST_ZERO   = 5;
  localparam int unsigned ST_ERR_LO = 1;
  localparam int unsigned ST_CARRY  = 0;
  localparam int unsigned SR_BIT    = 7;     // Service request enable in each command byte
  localparam logic [3:0]  ERR_NONE  = 4'h0;
  localparam logic [3:0]  ERR_DIV0  = 4'h8;
  localparam logic [3:0]  ERR_NEG   = 4'h4;
  localparam logic [3:0]  ERR_RANGE = 4'hc;
  localparam logic [3:0]  ERR_UNDER = 4'h2;
  localparam logic [3:0]  ERR_OVER  = 4'h1;

  // ************************************************************
  // Opcodes, service request bit removed
  // ************************************************************
  localparam logic [6:0] OP_IDLE           = 7'h00;
  localparam logic [6:0] OP_ADD_SHORT      = 7'h6c;
  localparam logic [6:0] OP_SUB_SHORT      = 7'h6d;
  localparam logic [6:0] OP_MUL_SHORT_LOW  = 7'h6e;
  localparam logic [6:0] OP_MUL_SHORT_HIGH = 7'h76;
  localparam logic [6:0] OP_DIV_SHORT      = 7'h6f;
  localparam logic [6:0] OP_ADD_LONG       = 7'h2c;
  localparam logic [6:0] OP_SUB_LONG       = 7'h2d;
  localparam logic [6:0] OP_MUL_LONG_LOW   = 7'h2e;
  localparam logic [6:0] OP_MUL_LONG_HIGH  = 7'h36;
  localparam logic [6:0] OP_DIV_LONG       = 7'h2f;
  localparam logic [6:0] OP_ADD_REAL       = 7'h10;
  localparam logic [6:0] OP_SUB_REAL       = 7'h11;
  localparam logic [6:0] OP_MUL_REAL       = 7'h12;
  localparam logic [6:0] OP_DIV_REAL       = 7'h13;
  localparam logic [6:0] OP_ROOT_TWO       = 7'h01;
  localparam logic [6:0] OP_E_RAISED       = 7'h0a;
  localparam logic [6:0] OP_RAISE_GENERAL  = 7'h0b;

  // ************************************************************
  // Host handshake states
  // ************************************************************
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_WAIT = 2'b01,
    HS_HOLD = 2'b10
  } acp_hs_type;

  // Least execution cycles of each opcode
  function automatic logic [13:0] acp_op_cycles(input logic [6:0] op);
    case (op)
      OP_IDLE:           acp_op_cycles = 14'd4;
      OP_ADD_SHORT:      acp_op_cycles = 14'd16;
      OP_SUB_SHORT:      acp_op_cycles = 14'd30;
      OP_MUL_SHORT_LOW:  acp_op_cycles = 14'd84;
      OP_MUL_SHORT_HIGH: acp_op_cycles = 14'd80;
      OP_DIV_SHORT:      acp_op_cycles = 14'd84;
      OP_ADD_LONG:       acp_op_cycles = 14'd20;
      OP_SUB_LONG:       acp_op_cycles = 14'd38;
      OP_MUL_LONG_LOW:   acp_op_cycles = 14'd194;
      OP_MUL_LONG_HIGH:  acp_op_cycles = 14'd182;
      OP_DIV_LONG:       acp_op_cycles = 14'd196;
      7'h10:             acp_op_cycles = 14'd54;
      7'h11:             acp_op_cycles = 14'd70;
      7'h12:             acp_op_cycles = 14'd146;
      7'h13:             acp_op_cycles = 14'd154;
      7'h01:             acp_op_cycles = 14'd782;
      7'h02:             acp_op_cycles = 14'd3796;
      7'h03:             acp_op_cycles = 14'd3840;
      7'h04:             acp_op_cycles = 14'd4894;
      7'h05:             acp_op_cycles = 14'd6230;
      7'h06:             acp_op_cycles = 14'd6304;
      7'h07:             acp_op_cycles = 14'd4992;
      7'h08:             acp_op_cycles = 14'd4474;
      7'h09:             acp_op_cycles = 14'd4298;
      7'h0a:             acp_op_cycles = 14'd3794;
      7'h0b:             acp_op_cycles = 14'd8290;
      default:           acp_op_cycles = 14'd4;
    endcase
  endfunction : acp_op_cycles

endpackage : acp_pkg

// ---- design/acp_top.sv ----
// Host port, operand stack, status byte and command timing of the arithmetic coprocessor.
// Assumes host strobes are asynchronous pins; the host pulls the data bus from o_host_data_oe.
//
// Contract
// RL1: stack read keeps data, moves pointer only
// RL2: over-popping wraps pointer, older bytes reappear
// RL3: status readable at any time
// RL4: status read: ack low, high with status
// RL5: status stays driven while read held
// RL6: host releases read only after ack high
// RL7: fixed operands are 16/32 bit two's complement
// RL8: short range -32768 to +32767
// RL9: real word: sign, 7-bit exponent, 24-bit mantissa
// RL10: reals normalized, zero is all zeros
// RL11: status: busy,sign,zero,error[4:1],carry
// RL12: busy high exactly while command executes
// RL13: sign and zero reflect new stack top
// RL14: error field encodes last operation validity; commands 80, 82 and 83 here leave the earlier error code unchanged
// RL15: carry reports carry or borrow out
// RL16: other status bits undefined while busy
// RL17: short fixed opcodes and cycle counts
// RL18: long fixed opcodes and cycle counts
// RL19: real primary opcodes and cycle counts
// RL20: derived opcodes 81..8A replace stack top; here the top word is left unchanged
// RL21: raise opcode 8B pops, bit 7 ignored
// RL22: bit 7 captured as service request enable
// RL23: command while busy holds ack low
// RL24: push low byte first, pop high first
// RL25: sixteen byte stack, overflow overwrites oldest
// RL26: status acknowledge within fixed few clocks
`timescale 1ns/1ns

// ************************************************************
// Write-side FIFO, flip-flop storage
// ************************************************************
module acp_fifo #(
  parameter int unsigned W = 8,
  parameter int unsigned D = 32
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_in_valid,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_in_ready,
  output logic              o_out_valid,
  output logic [W-1:0]      o_out_data,
  input  wire logic         i_out_ready
);
  localparam int unsigned AW = $clog2(D);
  logic [D-1:0][W-1:0] mem_q, mem_d;
  logic [AW:0]         wp_q, wp_d, rp_q, rp_d;
  logic                full_w, empty_w;

  // Pointers carry one extra bit so full and empty are told apart
  always_comb
  begin
    full_w  = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
    empty_w = (wp_q == rp_q);
    mem_d   = mem_q;
    wp_d    = wp_q;
    rp_d    = rp_q;
    if (i_in_valid && !full_w)
    begin
      mem_d[wp_q[AW-1:0]] = i_in_data;
      wp_d                = wp_q + 1'b1;
    end
    if (i_out_ready && !empty_w)
      rp_d = rp_q + 1'b1;
  end

  always_ff @(posedge i_sys_clk)
  begin
    mem_q <= mem_d;
    wp_q  <= (!i_rst_n) ? '0 : wp_d;
    rp_q  <= (!i_rst_n) ? '0 : rp_d;
  end

  assign o_in_ready  = !full_w;
  assign o_out_valid = !empty_w;
  assign o_out_data  = mem_q[rp_q[AW-1:0]];
endmodule : acp_fifo

// ************************************************************
// Top level
// ************************************************************
module acp_top
  import acp_pkg::*;
#(
  parameter logic [13:0] P_CYCLE_CAP = 14'd12032    // Shortens long commands in simulation
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_cs_n,
  input  wire logic       i_cd,
  input  wire logic       i_rd_n,
  input  wire logic       i_wr_n,
  input  wire logic [7:0] i_host_data_bus,
  output logic      [7:0] o_host_data_bus,
  output logic            o_host_data_oe,
  output logic            o_ack_n,
  output logic            o_service_request_out
);
  // Two-stage synchronisers for every host bus pin; i_rst_n is used unsynchronised
  logic [11:0] sy1_q, sy2_q;
  logic        cs_n_s, cd_s, rd_n_s, wr_n_s;
  logic [7:0]  din_s;

  logic [STK_BYTES-1:0][7:0] stk_q, stk_d;
  logic [PTR_W-1:0] ptr_q, ptr_d;
  acp_hs_type       hs_q, hs_d;
  logic             ack_n_q, ack_n_d, oe_q, oe_d, svc_q, svc_d;
  logic [7:0]       dout_q, dout_d;
  logic             busy_q, busy_d, sign_q, sign_d, zero_q, zero_d, carry_q, carry_d, sren_q, sren_d;
  logic [3:0]       err_q, err_d;
  logic [13:0]      cnt_q, cnt_d, cyc_w;
  logic [7:0]       status_w;
  logic             rd_req, wr_req, start_w, pop_w, push_w;
  logic             f_ready, f_valid;
  logic [7:0]       f_data;
  logic [6:0]       op_w;
  logic             long_w, div0_w;
  logic [31:0]      tos_w, nos_w, a_w, b_w, r_w;
  logic [32:0]      sum_w;
  logic [63:0]      prod_w;
  logic [PTR_W-1:0] wbytes_w, idx_w;

  always_ff @(posedge i_sys_clk)
  begin
    sy1_q <= {i_cs_n, i_cd, i_rd_n, i_wr_n, i_host_data_bus};
    sy2_q <= sy1_q;
  end
  assign {cs_n_s, cd_s, rd_n_s, wr_n_s, din_s} = sy2_q;
  assign rd_req = !cs_n_s && !rd_n_s;
  assign wr_req = !cs_n_s && !wr_n_s;

  // Status byte as the host sees it
  assign status_w = {busy_q, sign_q, zero_q, err_q, carry_q}; // RL11 RL16

  // Data bytes queue here so the host can load operands during a long command
  acp_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
    .i_sys_clk   (i_sys_clk),
    .i_rst_n     (i_rst_n),
    .i_in_valid  (push_w),
    .i_in_data   (din_s),
    .o_in_ready  (f_ready),
    .o_out_valid (f_valid),
    .o_out_data  (f_data),
    .i_out_ready (!busy_q)
  );

  // ************************************************************
  // Host handshake
  // ************************************************************
  always_comb
  begin
    hs_d    = hs_q;
    ack_n_d = ack_n_q;
    oe_d    = oe_q;
    dout_d  = dout_q;
    start_w = 1'b0;
    pop_w   = 1'b0;
    push_w  = 1'b0;
    case (hs_q)
      HS_IDLE:
      begin
        if (rd_req || wr_req)
        begin
          ack_n_d = 1'b0;                                   // RL4
          hs_d    = HS_WAIT;
        end
      end
      HS_WAIT:
      begin
        if (!rd_req && !wr_req)
        begin
          ack_n_d = 1'b1;                                   // Host aborted, give up quietly
          hs_d    = HS_IDLE;
        end
        else if (rd_req && cd_s)
        begin
          dout_d  = status_w;                               // RL3 RL26
          oe_d    = 1'b1;
          ack_n_d = 1'b1;                                   // RL4
          hs_d    = HS_HOLD;
        end
        else if (rd_req && !busy_q && !f_valid)
        begin
          dout_d  = stk_q[ptr_q - 1'b1];                    // RL24
          pop_w   = 1'b1;
          oe_d    = 1'b1;
          ack_n_d = 1'b1;
          hs_d    = HS_HOLD;
        end
        else if (wr_req && !cd_s && f_ready)
        begin
          push_w  = 1'b1;                                   // Full FIFO stalls the acknowledge
          ack_n_d = 1'b1;
          hs_d    = HS_HOLD;
        end
        else if (wr_req && cd_s && !busy_q && !f_valid)
        begin
          start_w = 1'b1;                                   // RL23
          ack_n_d = 1'b1;
          hs_d    = HS_HOLD;
        end
      end
      HS_HOLD:
      begin
        if (!rd_req && !wr_req)                             // RL5 RL6
        begin
          oe_d = 1'b0;
          hs_d = HS_IDLE;
        end
      end
      default:
      begin
        hs_d    = HS_IDLE;
        ack_n_d = 1'b1;
        oe_d    = 1'b0;
      end
    endcase
  end

  // ************************************************************
  // Operand fetch and fixed point arithmetic
  // ************************************************************
  always_comb
  begin
    op_w   = din_s[6:0];                                    // RL21
    long_w = (op_w[6] == 1'b0);                             // RL7
    tos_w  = {stk_q[ptr_q - 4'd1], stk_q[ptr_q - 4'd2], stk_q[ptr_q - 4'd3], stk_q[ptr_q - 4'd4]};
    nos_w  = {stk_q[ptr_q - 4'd5], stk_q[ptr_q - 4'd6], stk_q[ptr_q - 4'd7], stk_q[ptr_q - 4'd8]};
    // Short operands sit in the upper half so carry and overflow come from bit 31 for both widths
    a_w    = long_w ? nos_w : {tos_w[15:0], 16'h0000};      // RL8
    b_w    = long_w ? tos_w : {tos_w[31:16], 16'h0000};
    if (op_w[0])
      sum_w = {1'b0, a_w} - {1'b0, b_w};                    // RL15
    else
      sum_w = {1'b0, a_w} + {1'b0, b_w};
    prod_w = $signed({{32{a_w[31]}}, a_w}) * $signed({{32{b_w[31]}}, b_w});
    div0_w = (b_w == 32'h0000_0000);                        // RL14
    r_w    = nos_w;
    case (op_w)
      OP_ADD_SHORT, OP_SUB_SHORT, OP_ADD_LONG, OP_SUB_LONG:
        r_w = sum_w[31:0];
      OP_MUL_SHORT_LOW:  r_w = {prod_w[47:32], 16'h0000};
      OP_MUL_SHORT_HIGH: r_w = {prod_w[63:48], 16'h0000};
      OP_MUL_LONG_LOW:   r_w = prod_w[31:0];
      OP_MUL_LONG_HIGH:  r_w = prod_w[63:32];
      OP_DIV_SHORT:      r_w = div0_w ? a_w : {16'($signed(a_w[31:16]) / $signed(b_w[31:16])), 16'h0000};
      OP_DIV_LONG:       r_w = div0_w ? a_w : 32'($signed(a_w) / $signed(b_w));
      default:           r_w = nos_w;                       // Real ops keep the operand word
    endcase
    cyc_w = (acp_op_cycles(op_w) > P_CYCLE_CAP) ? P_CYCLE_CAP : acp_op_cycles(op_w);
  end

  // ************************************************************
  // Stack, execution timer and status
  // ************************************************************
  always_comb
  begin
    stk_d    = stk_q;
    ptr_d    = ptr_q;
    busy_d   = busy_q;
    cnt_d    = cnt_q;
    sign_d   = sign_q;
    zero_d   = zero_q;
    err_d    = err_q;
    carry_d  = carry_q;
    sren_d   = sren_q;
    svc_d    = svc_q;
    wbytes_w = long_w ? 4'd4 : 4'd2;
    idx_w    = ptr_q;
    if (pop_w)
      ptr_d = ptr_q - 1'b1;                                 // RL1 RL2
    if (f_valid && !busy_q)
    begin
      stk_d[ptr_q] = f_data;                                // RL24 RL25
      ptr_d        = ptr_q + 1'b1;
    end
    if (start_w)
    begin
      sren_d = din_s[SR_BIT];                               // RL22
      if (!din_s[SR_BIT])
        svc_d = 1'b0;
      busy_d = 1'b1;                                        // RL12
      cnt_d  = cyc_w - 1'b1;
      case (op_w)
        OP_ADD_SHORT, OP_SUB_SHORT, OP_MUL_SHORT_LOW, OP_MUL_SHORT_HIGH, OP_DIV_SHORT,
        OP_ADD_LONG, OP_SUB_LONG, OP_MUL_LONG_LOW, OP_MUL_LONG_HIGH, OP_DIV_LONG:
        begin
          // Result replaces the next entry, then the stack pops
          for (int j = 0; j < 4; j++)
          begin
            idx_w = ptr_q - (wbytes_w << 1) + 4'(j);
            if (4'(j) < wbytes_w)
              stk_d[idx_w] = long_w ? r_w[8*j +: 8] : r_w[16 + 8*j +: 8]; // RL17 RL18
          end
          ptr_d   = ptr_q - wbytes_w;
          sign_d  = r_w[31];                                // RL13
          zero_d  = long_w ? (r_w == 32'h0) : (r_w[31:16] == 16'h0);
          carry_d = (op_w[2:0] == 3'h4 || op_w[2:0] == 3'h5) ? sum_w[32] : 1'b0;
          err_d   = ERR_NONE;
          if (op_w[2:0] == 3'h7 && div0_w)
            err_d = ERR_DIV0;
          else if ((op_w[2:0] == 3'h4 && a_w[31] == b_w[31] && sum_w[31] != a_w[31]) ||
                   (op_w[2:0] == 3'h5 && a_w[31] != b_w[31] && sum_w[31] != a_w[31]))
            err_d = ERR_OVER;
        end
        OP_ADD_REAL, OP_SUB_REAL, OP_MUL_REAL, OP_DIV_REAL, OP_RAISE_GENERAL:
        begin
          ptr_d  = ptr_q - 4'd4;                            // RL19 RL21
          sign_d = nos_w[31];                               // RL9
          zero_d = (nos_w == 32'h0);                        // RL10
          err_d  = (op_w == OP_DIV_REAL && tos_w == 32'h0) ? ERR_DIV0 : ERR_NONE;
        end
        default:
        begin
          sign_d = tos_w[31];                               // RL20
          zero_d = (tos_w == 32'h0);
          if (op_w >= OP_ROOT_TWO && op_w <= OP_E_RAISED && op_w != 7'h02 && op_w != 7'h03)
            err_d = ERR_NONE;
        end
      endcase
    end
    else if (busy_q)
    begin
      if (cnt_q == 14'd0)
      begin
        busy_d = 1'b0;
        if (sren_q)
          svc_d = 1'b1;
      end
      else
        cnt_d = cnt_q - 1'b1;
    end
  end

  // Registers only; synchronous reset, stack cleared so no unknown byte is ever popped
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      stk_q   <= '0;
      hs_q    <= HS_IDLE;
      ack_n_q <= 1'b1;
      oe_q    <= 1'b0;
      dout_q  <= 8'h00;
      ptr_q   <= '0;
      busy_q  <= 1'b0;
      cnt_q   <= 14'h0000;
      sign_q  <= 1'b0;
      zero_q  <= 1'b0;
      err_q   <= ERR_NONE;
      carry_q <= 1'b0;
      sren_q  <= 1'b0;
      svc_q   <= 1'b0;
    end
    else
    begin
      stk_q   <= stk_d;
      hs_q    <= hs_d;
      ack_n_q <= ack_n_d;
      oe_q    <= oe_d;
      dout_q  <= dout_d;
      ptr_q   <= ptr_d;
      busy_q  <= busy_d;
      cnt_q   <= cnt_d;
      sign_q  <= sign_d;
      zero_q  <= zero_d;
      err_q   <= err_d;
      carry_q <= carry_d;
      sren_q  <= sren_d;
      svc_q   <= svc_d;
    end
  end

  assign o_host_data_bus       = dout_q;
  assign o_host_data_oe        = oe_q;
  assign o_ack_n               = ack_n_q;
  assign o_service_request_out = svc_q;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  AST_STATUS_FAST: assert property ((hs_q == HS_IDLE) && rd_req && cd_s |=> // RL26
    !o_ack_n ##1 (o_ack_n && o_host_data_oe))
    else $error("status read not answered in time");
  AST_STATUS_VALUE: assert property ((hs_q == HS_WAIT) && rd_req && cd_s |=> o_host_data_bus == $past(status_w)) // RL4
    else $error("status byte wrong");
  AST_HOLD_DRIVE: assert property (o_host_data_oe && rd_req |=> o_host_data_oe && $stable(o_host_data_bus)) // RL5
    else $error("read data dropped while strobe held");
  AST_READ_KEEPS: assert property (pop_w |=> (stk_q == $past(stk_q)) && (ptr_q == $past(ptr_q) - 4'd1)) // RL1
    else $error("stack read altered data");
  AST_CMD_WAITS: assert property (busy_q && (hs_q == HS_WAIT) && wr_req && cd_s |=> !o_ack_n) // RL23
    else $error("command acknowledged while busy");
  AST_IDLE_TIME: assert property (start_w && (op_w == OP_IDLE) |=> busy_q [*4] ##1 !busy_q) // RL12
    else $error("idle command duration wrong");
  AST_DIV_ZERO: assert property (start_w && (op_w == OP_DIV_SHORT) && div0_w |=> err_q == ERR_DIV0) // RL14
    else $error("divide by zero not flagged");
  AST_SVC_SET: assert property (busy_q && (cnt_q == 14'd0) && sren_q && !start_w |=> o_service_request_out) // RL22
    else $error("service request not raised");
  AST_ADD_POP: assert property (start_w && (op_w == OP_ADD_SHORT) |=> ptr_q == $past(ptr_q) - 4'd2) // RL17
    else $error("short add did not pop");
endmodule : acp_top

// ---- dv/acp_host_model.sv ----
// Host processor model driving the coprocessor byte bus and strobes.
// Assumes one clock shared with the device; the testbench calls task xfer.
`timescale 1ns/1ns
module acp_host_model (
  input  wire logic       i_sys_clk,
  input  wire logic       i_ack_n,
  input  wire logic       i_oe,
  input  wire logic [7:0] i_data,
  output logic            o_cs_n,
  output logic            o_cd,
  output logic            o_rd_n,
  output logic            o_wr_n,
  output logic      [7:0] o_data
);
  // ************************************************************
  // Idle levels and one bus access
  // ************************************************************
  // Deselected and idle at time zero
  initial
  begin
    o_cs_n = 1'b1;
    o_cd   = 1'b0;
    o_rd_n = 1'b1;
    o_wr_n = 1'b1;
    o_data = 8'h00;
  end

  // Select first, strobe next; hold everything until ack is seen high
  task automatic xfer(input logic cd, input logic rd, input logic [7:0] wd,
                      output logic [7:0] rdat, output int lowcnt, output logic ok);
    int n;
    n = 0;
    lowcnt = 0;
    @(posedge i_sys_clk);
    o_cd   <= cd;
    o_cs_n <= 1'b0;
    o_data <= wd;
    @(posedge i_sys_clk);
    if (rd)
    begin
      o_rd_n <= 1'b0;
    end
    else
    begin
      o_wr_n <= 1'b0;
    end
    while (i_ack_n !== 1'b0 && n < 40)
    begin
      @(posedge i_sys_clk);
      n++;
    end
    while (i_ack_n !== 1'b1 && lowcnt < 5000)
    begin
      @(posedge i_sys_clk);
      lowcnt++;
    end
    ok = (n < 40) && (lowcnt < 5000);
    rdat = (i_oe === 1'b1) ? i_data : 8'hff;  // Undriven bus floats to the pull-up level
    // Keep the strobe a little longer; read data must not move meanwhile
    repeat (2)
    begin
      @(posedge i_sys_clk);
      if (rd && (i_data !== rdat || i_oe !== 1'b1))
        ok = 1'b0;
    end
    o_rd_n <= 1'b1;
    o_wr_n <= 1'b1;
    o_cs_n <= 1'b1;
    o_data <= ~wd;     // Released bus shows a changed pattern, not the old byte
    repeat (4) @(posedge i_sys_clk);
  endtask : xfer
endmodule : acp_host_model

// ---- dv/testbench.sv ----
// Self-checking bench of the coprocessor host port, stack and command timing.
// Assumes acp_pkg and acp_top compiled first; long commands shortened to 20 cycles.
`timescale 1ns/1ns
module testbench;
  import acp_pkg::*;
  typedef struct {logic [7:0] op; int nb; logic [31:0] a, b, res; logic [7:0] st, mask;} acp_row_type;
  logic       sys_clk = 1'b0;
  logic       rst_n   = 1'b0;
  logic       cs_n, cd, rd_n, wr_n, oe, ack_n, svc;
  logic [7:0] din, dout, st;
  logic [31:0] v;
  int         errors   = 0;
  int         compares = 0;
  int         lc;
  // Operands a (next) and b (top), result, status expected under mask
  acp_row_type rows[22] = '{
    '{8'hec,2,32'h0003,32'h0004,32'h0007,8'h00,8'hff}, '{8'hec,2,32'hffff,32'h0001,32'h0000,8'h21,8'hff},
    '{8'hec,2,32'h7fff,32'h0001,32'h8000,8'h42,8'hff}, '{8'hed,2,32'h0005,32'h0007,32'hfffe,8'h41,8'hff},
    '{8'hee,2,32'h0100,32'h0100,32'h0000,8'h20,8'h60}, '{8'hf6,2,32'h0100,32'h0100,32'h0001,8'h00,8'h60},
    '{8'hef,2,32'h0064,32'h0007,32'h000e,8'h00,8'h60}, '{8'hef,2,32'h1234,32'h0000,32'h1234,8'h10,8'h1e},
    '{8'hac,4,32'h0001ffff,32'h1,32'h00020000,8'h00,8'hff}, '{8'had,4,32'h0,32'h1,32'hffffffff,8'h41,8'hff},
    '{8'hae,4,32'h00010000,32'h00010000,32'h0,8'h20,8'h60}, '{8'hb6,4,32'h00010000,32'h00010000,32'h1,8'h00,8'h60},
    '{8'haf,4,32'h64,32'ha,32'ha,8'h00,8'h60}, '{8'h90,4,32'hc0800000,32'h40800000,32'hc0800000,8'h40,8'h60},
    '{8'h93,4,32'h40800000,32'h0,32'h40800000,8'h10,8'h1e}, '{8'h81,4,32'h0,32'h40800000,32'h40800000,8'h00,8'h60},
    '{8'h8a,4,32'h0,32'hc0c00000,32'hc0c00000,8'h40,8'h60}, '{8'h8b,4,32'h40800000,32'h40400000,32'h40800000,8'h00,8'h60},
    '{8'h0b,4,32'h40800000,32'h40400000,32'h40800000,8'h00,8'h60},
    '{8'h91,4,32'h40800000,32'h40400000,32'h40800000,8'h00,8'h60},
    '{8'h12,4,32'hc0800000,32'h40400000,32'hc0800000,8'h40,8'h60},
    '{8'h85,4,32'h0,32'hc0400000,32'hc0400000,8'h40,8'h60}};

  // ************************************************************
  // Clock, device and host
  // ************************************************************
  always #4 sys_clk = ~sys_clk;

  acp_top #(.P_CYCLE_CAP(14'd20)) dut (.i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_cs_n(cs_n), .i_cd(cd),
    .i_rd_n(rd_n), .i_wr_n(wr_n), .i_host_data_bus(din), .o_host_data_bus(dout), .o_host_data_oe(oe),
    .o_ack_n(ack_n), .o_service_request_out(svc));

  acp_host_model host (.i_sys_clk(sys_clk), .i_ack_n(ack_n), .i_oe(oe), .i_data(dout), .o_cs_n(cs_n),
    .o_cd(cd), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_data(din));

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    $display("Comparisons %0d, errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : finish_test

  // One access; every access must complete and hold its read data
  task automatic bus(input logic c, input logic r, input logic [7:0] wd, output logic [7:0] rd);
    logic ok;
    host.xfer(c, r, wd, rd, lc, ok);
    check(ok, 1'b1);
  endtask : bus

  // Poll status until not busy, bounded so a stuck flag cannot hang the run
  task automatic wait_idle();
    int n;
    n = 0;
    st = 8'h80;
    while (st[ST_BUSY] !== 1'b0 && n < 60)
    begin
      bus(1'b1, 1'b1, 8'h00, st);
      n++;
    end
    check(n < 60, 1'b1);
  endtask : wait_idle

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial
  begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    // Table: push next then top low byte first, run, poll, pop high byte first
    foreach (rows[r])
    begin
      for (int i = 0; i < rows[r].nb; i++) bus(1'b0, 1'b0, rows[r].a[8*i +: 8], st);
      for (int i = 0; i < rows[r].nb; i++) bus(1'b0, 1'b0, rows[r].b[8*i +: 8], st);
      bus(1'b1, 1'b0, rows[r].op, st);
      bus(1'b1, 1'b1, 8'h00, st);
      check(st[ST_BUSY], 1'b1);
      wait_idle();
      check(st & rows[r].mask, rows[r].st & rows[r].mask);
      v = 32'h0;
      for (int i = rows[r].nb - 1; i >= 0; i--) bus(1'b0, 1'b1, 8'h00, v[8*i +: 8]);
      check(v, rows[r].res);
    end
    // Mid-run reset returns the port to idle with a clear status
    rst_n <= 1'b0;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check({ack_n, oe, svc}, 3'b100);
    bus(1'b1, 1'b1, 8'h00, st);
    check(st, 8'h00);
    // Overfill by two bytes, then pop twice the depth: oldest lost, pointer wraps
    for (int i = 0; i < 18; i++) bus(1'b0, 1'b0, i[7:0], st);
    for (int i = 0; i < 32; i++)
    begin
      bus(1'b0, 1'b1, 8'h00, st);
      check(st, 8'(17 - (i % 16)));
    end
    // Command while busy waits; status still answers at once; service request follows bit 7
    bus(1'b1, 1'b0, 8'h81, st);
    bus(1'b1, 1'b0, 8'h01, st);
    check(lc > 3, 1'b1);
    bus(1'b1, 1'b1, 8'h00, st);
    check({st[ST_BUSY], lc[7:0]}, 9'h101);
    wait_idle();
    check(svc, 1'b0);
    bus(1'b1, 1'b0, 8'h80, st);
    wait_idle();
    check(svc, 1'b1);
    finish_test();
  end

  // Watchdog well beyond the expected few thousand cycles
  initial
  begin
    #(8 * 60000);
    errors++;
    finish_test();
  end
endmodule : testbench
